// ---- bsb_defines.vh ----
// Purpose: shared constants of the branch, skip and bit-operation execution unit
// Assumes: included by bsb_exec.v and by the testbench
// Notes: command word layout, opcodes, flag positions, register map and cycle counts
`ifndef BSB_DEFINES_VH
`define BSB_DEFINES_VH

// ************************************************************
// command word fields
// ************************************************************
`define BSB_F_OP 4:0
`define BSB_F_RD 9:5
`define BSB_F_IO 15:10
`define BSB_F_BIT 18:16
`define BSB_F_LONG 19
`define BSB_F_K 31:24

// ************************************************************
// opcodes
// ************************************************************
`define BSB_OP_COMPARE_IMMEDIATE 5'h00
`define BSB_OP_SKIP_REG_BIT_CLEAR 5'h01
`define BSB_OP_SKIP_REG_BIT_SET 5'h02
`define BSB_OP_SKIP_IO_BIT_CLEAR 5'h03
`define BSB_OP_SKIP_IO_BIT_SET 5'h04
`define BSB_OP_BRANCH_FLAG_SET 5'h05
`define BSB_OP_BRANCH_FLAG_CLEAR 5'h06
`define BSB_OP_BRANCH_EQUAL 5'h07
`define BSB_OP_BRANCH_NOT_EQUAL 5'h08
`define BSB_OP_BRANCH_CARRY_SET 5'h09
`define BSB_OP_BRANCH_CARRY_CLEAR 5'h0a
`define BSB_OP_BRANCH_SAME_OR_HIGHER 5'h0b
`define BSB_OP_BRANCH_LOWER 5'h0c
`define BSB_OP_BRANCH_MINUS 5'h0d
`define BSB_OP_BRANCH_PLUS 5'h0e
`define BSB_OP_BRANCH_SIGNED_GE 5'h0f
`define BSB_OP_BRANCH_SIGNED_LT 5'h10
`define BSB_OP_BRANCH_HALF_CARRY_SET 5'h11
`define BSB_OP_BRANCH_HALF_CARRY_CLEAR 5'h12
`define BSB_OP_BRANCH_COPY_FLAG_SET 5'h13
`define BSB_OP_BRANCH_COPY_FLAG_CLEAR 5'h14
`define BSB_OP_BRANCH_OVERFLOW_SET 5'h15
`define BSB_OP_BRANCH_OVERFLOW_CLEAR 5'h16
`define BSB_OP_BRANCH_IRQ_ENABLED 5'h17
`define BSB_OP_BRANCH_IRQ_DISABLED 5'h18
`define BSB_OP_SET_IO_BIT 5'h19
`define BSB_OP_CLEAR_IO_BIT 5'h1a
`define BSB_OP_LOGICAL_SHIFT_LEFT 5'h1b
`define BSB_OP_LOGICAL_SHIFT_RIGHT 5'h1c
`define BSB_OP_LAST 5'h1c

// ************************************************************
// status flag register bits
// ************************************************************
`define BSB_FL_C 3'd0
`define BSB_FL_Z 3'd1
`define BSB_FL_N 3'd2
`define BSB_FL_V 3'd3
`define BSB_FL_S 3'd4
`define BSB_FL_H 3'd5
`define BSB_FL_T 3'd6
`define BSB_FL_I 3'd7

// ************************************************************
// register map (byte addresses, gpr/io high address bits, reset values)
// ************************************************************
`define BSB_A_CMD 12'h000
`define BSB_A_PC 12'h004
`define BSB_A_STATUS_FLAG_REGISTER 12'h008
`define BSB_A_STAT 12'h00c
`define BSB_A_GPR_HI 5'h02
`define BSB_A_IO_HI 4'h2
`define BSB_RST_PC 16'h0000
`define BSB_RST_STATUS_FLAG_REGISTER 8'h00

// ************************************************************
// cycle counts
// ************************************************************
`define BSB_CYC_1 2'd1
`define BSB_CYC_2 2'd2
`define BSB_CYC_3 2'd3
`endif

// ---- bsb_exec.v ----
// Purpose: executes compare-immediate, skips, flag branches, io bit set/clear and shifts
// Assumes: apb3 slave, one clock, pce freezes all state including the bus side
// Notes: one command is issued per accepted write to the command register
`timescale 1ns/10ps
`include "bsb_defines.vh"

module bsb_exec #(
   parameter PC_W = 16,
   parameter AW = 12
) (
   input wire pclk,
   input wire presetn,
   input wire pce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   output reg pready,
   output reg [31:0] prdata,
   output reg pslverr,
   output reg busy,
   output reg done,
   output reg [PC_W-1:0] pc,
   output reg [7:0] status_flag_register
);

   // ************************************************************
   // storage
   // ************************************************************
   reg [7:0] gpr [0:31];
   reg [7:0] io [0:63];
   reg [31:0] cmd_r;
   reg [1:0] cnt_r;

   wire [4:0] op = cmd_r[`BSB_F_OP];
   wire [4:0] rd_idx = cmd_r[`BSB_F_RD];
   wire [5:0] io_idx = cmd_r[`BSB_F_IO];
   wire [2:0] bsel = cmd_r[`BSB_F_BIT];
   wire [7:0] kval = cmd_r[`BSB_F_K];
   wire [7:0] rd_val = gpr[rd_idx];
   wire [7:0] io_val = io[io_idx];
   // offset is a signed word displacement
   wire [PC_W-1:0] k_ext = {{(PC_W-8){kval[7]}}, kval};
   wire [7:0] cmp_res = rd_val - kval;

   // ************************************************************
   // execution decode
   // ************************************************************
   reg is_br;
   reg is_skip;
   reg cond;
   reg [1:0] cyc;
   reg [PC_W-1:0] pc_nxt;
   reg [7:0] status_flag_register_nxt;
   reg gpr_we;
   reg [7:0] gpr_wd;
   reg io_we;
   reg [7:0] io_wd;

   always @*
   begin
      is_br = 1'b0;
      is_skip = 1'b0;
      cond = 1'b0;
      status_flag_register_nxt = status_flag_register;
      gpr_we = 1'b0;
      gpr_wd = rd_val;
      io_we = 1'b0;
      io_wd = io_val;
      case (op)
         `BSB_OP_COMPARE_IMMEDIATE:
         begin
            status_flag_register_nxt[`BSB_FL_H] = (~rd_val[3] & kval[3]) | (kval[3] & cmp_res[3]) |
               (cmp_res[3] & ~rd_val[3]);
            status_flag_register_nxt[`BSB_FL_V] = (rd_val[7] & ~kval[7] & ~cmp_res[7]) |
               (~rd_val[7] & kval[7] & cmp_res[7]);
            status_flag_register_nxt[`BSB_FL_C] = (~rd_val[7] & kval[7]) | (kval[7] & cmp_res[7]) |
               (cmp_res[7] & ~rd_val[7]);
            status_flag_register_nxt[`BSB_FL_N] = cmp_res[7];
            status_flag_register_nxt[`BSB_FL_Z] = (cmp_res == 8'h00);
         end
         `BSB_OP_SKIP_REG_BIT_CLEAR:
         begin
            is_skip = 1'b1;
            cond = ~rd_val[bsel];
         end
         `BSB_OP_SKIP_REG_BIT_SET:
         begin
            is_skip = 1'b1;
            cond = rd_val[bsel];
         end
         `BSB_OP_SKIP_IO_BIT_CLEAR:
         begin
            is_skip = 1'b1;
            cond = ~io_val[bsel];
         end
         `BSB_OP_SKIP_IO_BIT_SET:
         begin
            is_skip = 1'b1;
            cond = io_val[bsel];
         end
         `BSB_OP_BRANCH_FLAG_SET:
         begin
            is_br = 1'b1;
            cond = status_flag_register[bsel];
         end
         `BSB_OP_BRANCH_FLAG_CLEAR:
         begin
            is_br = 1'b1;
            cond = ~status_flag_register[bsel];
         end
         `BSB_OP_BRANCH_EQUAL:
         begin
            is_br = 1'b1;
            cond = status_flag_register[`BSB_FL_Z];
         end
         `BSB_OP_BRANCH_NOT_EQUAL:
         begin
            is_br = 1'b1;
            cond = ~status_flag_register[`BSB_FL_Z];
         end
         `BSB_OP_BRANCH_CARRY_SET, `BSB_OP_BRANCH_LOWER:
         begin
            is_br = 1'b1;
            cond = status_flag_register[`BSB_FL_C];
         end
         `BSB_OP_BRANCH_CARRY_CLEAR, `BSB_OP_BRANCH_SAME_OR_HIGHER:
         begin
            is_br = 1'b1;
            cond = ~status_flag_register[`BSB_FL_C];
         end
         `BSB_OP_BRANCH_MINUS:
         begin
            is_br = 1'b1;
            cond = status_flag_register[`BSB_FL_N];
         end
         `BSB_OP_BRANCH_PLUS:
         begin
            is_br = 1'b1;
            cond = ~status_flag_register[`BSB_FL_N];
         end
         `BSB_OP_BRANCH_SIGNED_GE:
         begin
            is_br = 1'b1;
            cond = ~(status_flag_register[`BSB_FL_N] ^ status_flag_register[`BSB_FL_V]);
         end
         `BSB_OP_BRANCH_SIGNED_LT:
         begin
            is_br = 1'b1;
            cond = status_flag_register[`BSB_FL_N] ^ status_flag_register[`BSB_FL_V];
         end
         `BSB_OP_BRANCH_HALF_CARRY_SET:
         begin
            is_br = 1'b1;
            cond = status_flag_register[`BSB_FL_H];
         end
         `BSB_OP_BRANCH_HALF_CARRY_CLEAR:
         begin
            is_br = 1'b1;
            cond = ~status_flag_register[`BSB_FL_H];
         end
         `BSB_OP_BRANCH_COPY_FLAG_SET:
         begin
            is_br = 1'b1;
            cond = status_flag_register[`BSB_FL_T];
         end
         `BSB_OP_BRANCH_COPY_FLAG_CLEAR:
         begin
            is_br = 1'b1;
            cond = ~status_flag_register[`BSB_FL_T];
         end
         `BSB_OP_BRANCH_OVERFLOW_SET:
         begin
            is_br = 1'b1;
            cond = status_flag_register[`BSB_FL_V];
         end
         `BSB_OP_BRANCH_OVERFLOW_CLEAR:
         begin
            is_br = 1'b1;
            cond = ~status_flag_register[`BSB_FL_V];
         end
         `BSB_OP_BRANCH_IRQ_ENABLED:
         begin
            is_br = 1'b1;
            cond = status_flag_register[`BSB_FL_I];
         end
         `BSB_OP_BRANCH_IRQ_DISABLED:
         begin
            is_br = 1'b1;
            cond = ~status_flag_register[`BSB_FL_I];
         end
         `BSB_OP_SET_IO_BIT:
         begin
            io_we = 1'b1;
            io_wd = io_val | (8'h01 << bsel);
         end
         `BSB_OP_CLEAR_IO_BIT:
         begin
            io_we = 1'b1;
            io_wd = io_val & ~(8'h01 << bsel);
         end
         `BSB_OP_LOGICAL_SHIFT_LEFT:
         begin
            gpr_we = 1'b1;
            gpr_wd = {rd_val[6:0], 1'b0};
            status_flag_register_nxt[`BSB_FL_C] = rd_val[7];
            status_flag_register_nxt[`BSB_FL_N] = rd_val[6];
            status_flag_register_nxt[`BSB_FL_V] = rd_val[6] ^ rd_val[7];
            status_flag_register_nxt[`BSB_FL_Z] = (rd_val[6:0] == 7'h00);
         end
         `BSB_OP_LOGICAL_SHIFT_RIGHT:
         begin
            gpr_we = 1'b1;
            gpr_wd = {1'b0, rd_val[7:1]};
            status_flag_register_nxt[`BSB_FL_C] = rd_val[0];
            status_flag_register_nxt[`BSB_FL_N] = 1'b0;
            status_flag_register_nxt[`BSB_FL_V] = rd_val[0];
            status_flag_register_nxt[`BSB_FL_Z] = (rd_val[7:1] == 7'h00);
         end
         default:
         begin
            status_flag_register_nxt = status_flag_register;
         end
      endcase
      // sign flag kept consistent with N and V for the flag-writing ops
      status_flag_register_nxt[`BSB_FL_S] = (is_br | is_skip | io_we) ? status_flag_register[`BSB_FL_S] :
         (status_flag_register_nxt[`BSB_FL_N] ^ status_flag_register_nxt[`BSB_FL_V]);
      if (is_br && cond)
      begin
         cyc = `BSB_CYC_2;
         pc_nxt = pc + k_ext + {{(PC_W-1){1'b0}}, 1'b1};
      end
      else if (is_skip && cond && cmd_r[`BSB_F_LONG])
      begin
         cyc = `BSB_CYC_3;
         pc_nxt = pc + {{(PC_W-2){1'b0}}, 2'd3};
      end
      else if (is_skip && cond)
      begin
         cyc = `BSB_CYC_2;
         pc_nxt = pc + {{(PC_W-2){1'b0}}, 2'd2};
      end
      else
      begin
         cyc = io_we ? `BSB_CYC_2 : `BSB_CYC_1;
         pc_nxt = pc + {{(PC_W-1){1'b0}}, 1'b1};
      end
   end

   // ************************************************************
   // apb decode
   // ************************************************************
   wire acc = psel & penable;
   wire hit_cmd = (paddr == `BSB_A_CMD);
   wire hit_pc = (paddr == `BSB_A_PC);
   wire hit_status_flag_register = (paddr == `BSB_A_STATUS_FLAG_REGISTER);
   wire hit_stat = (paddr == `BSB_A_STAT);
   wire hit_gpr = (paddr[11:7] == `BSB_A_GPR_HI) && (paddr[1:0] == 2'b00);
   wire hit_io = (paddr[11:8] == `BSB_A_IO_HI) && (paddr[1:0] == 2'b00);
   wire mapped = hit_cmd | hit_pc | hit_status_flag_register | hit_stat | hit_gpr | hit_io;
   // writes are refused while a command runs so its operands cannot shift under it
   wire bad = ~mapped | (pwrite & (busy | hit_stat)) |
      (pwrite & hit_cmd & (pwdata[`BSB_F_OP] > `BSB_OP_LAST));
   wire wr_fire = acc & pready & pwrite & ~pslverr;
   wire start = wr_fire & hit_cmd;
   wire finish = busy & (cnt_r == cyc);

   reg [31:0] rd_mux;

   always @*
   begin
      rd_mux = 32'h00000000;
      if (hit_cmd)
         rd_mux = cmd_r;
      else if (hit_pc)
         rd_mux = {{(32-PC_W){1'b0}}, pc};
      else if (hit_status_flag_register)
         rd_mux = {24'h000000, status_flag_register};
      else if (hit_stat)
         rd_mux = {28'h0000000, cnt_r, done, busy};
      else if (hit_gpr)
         rd_mux = {24'h000000, gpr[paddr[6:2]]};
      else if (hit_io)
         rd_mux = {24'h000000, io[paddr[7:2]]};
   end

   // ************************************************************
   // bus slave: one wait state, outputs registered
   // ************************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (pce)
      begin
         if (acc && !pready)
         begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= bad;
         end
         else
         begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // ************************************************************
   // sequencing and architectural state
   // ************************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_r <= 32'h00000000;
         cnt_r <= 2'd0;
         busy <= 1'b0;
         done <= 1'b0;
         pc <= `BSB_RST_PC;
         status_flag_register <= `BSB_RST_STATUS_FLAG_REGISTER;
      end
      else if (pce)
      begin
         done <= finish;
         if (start)
         begin
            cmd_r <= pwdata;
            busy <= 1'b1;
            cnt_r <= `BSB_CYC_1;
         end
         else if (finish)
         begin
            busy <= 1'b0;
            pc <= pc_nxt;
            status_flag_register <= status_flag_register_nxt;
         end
         else if (busy)
            cnt_r <= cnt_r + 2'd1;
         if (wr_fire && hit_pc)
            pc <= pwdata[PC_W-1:0];
         if (wr_fire && hit_status_flag_register)
            status_flag_register <= pwdata[7:0];
      end
   end

   // memories are data, not control, and carry no reset
   always @(posedge pclk)
   begin
      if (pce)
      begin
         if (finish && gpr_we)
            gpr[rd_idx] <= gpr_wd;
         else if (wr_fire && hit_gpr)
            gpr[paddr[6:2]] <= pwdata[7:0];
         if (finish && io_we)
            io[io_idx] <= io_wd;
         else if (wr_fire && hit_io)
            io[paddr[7:2]] <= pwdata[7:0];
      end
   end

endmodule

// ---- bsb_exec_asserts.sv ----
// Purpose: port checker for the execution unit
// Assumes: pce dropped only while no command runs
// Notes: bound to every bsb_exec instance
`timescale 1ns/10ps
module bsb_exec_chk #(
   parameter PC_W = 16,
   parameter AW = 12
) (
   input logic pclk,
   input logic presetn,
   input logic pce,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [AW-1:0] paddr,
   input logic [31:0] pwdata,
   input logic pready,
   input logic [31:0] prdata,
   input logic pslverr,
   input logic busy,
   input logic done,
   input logic [PC_W-1:0] pc,
   input logic [7:0] status_flag_register
);
   wire wr_hit = psel && penable && pready && pwrite;
   wire go = wr_hit && paddr == {AW{1'b0}} && !pslverr && !busy;
   // ****************
   // properties
   // ****************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_cmd_starts: assert property (go |=> busy)
      else $error("command did not start");
   a_one_cycle: assert property (go && (pwdata[4:0] == 5'h00 || pwdata[4:0] > 5'h1a)
      |=> busy ##1 !busy)
      else $error("single cycle op wrong length");
   a_io_two: assert property (go && (pwdata[4:0] == 5'h19 || pwdata[4:0] == 5'h1a)
      |=> busy ##1 busy ##1 !busy)
      else $error("io bit op wrong length");
   a_busy_bound: assert property ($rose(busy) |-> ##[1:3] !busy)
      else $error("busy too long");
   a_done_follows: assert property ($fell(busy) |-> done)
      else $error("no done after busy");
   a_done_pulse: assert property (done |-> !busy && $past(busy) ##1 !done)
      else $error("done malformed");
   // pc and flags only move at command end or on an accepted write
   a_pc_quiet: assert property (!busy && !wr_hit |=> $stable(pc))
      else $error("pc moved while idle");
   a_flags_quiet: assert property (!busy && !wr_hit |=> $stable(status_flag_register))
      else $error("flags moved while idle");
   a_ready_access: assert property (pready |-> psel && penable && $past(penable) ##1 !pready)
      else $error("ready outside access");
   a_align_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
      else $error("misaligned access accepted");
endmodule
bind bsb_exec bsb_exec_chk #(.PC_W(PC_W), .AW(AW)) u_chk (.pclk(pclk), .presetn(presetn),
   .pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .busy(busy),
   .done(done), .pc(pc), .status_flag_register(status_flag_register));

// ---- tb_branch_skip_bitop_exec.sv ----
// Purpose: self-checking bench for the execution unit
// Assumes: apb master in the bench, pce dropped only while the unit is idle
// Notes: a behavioural model predicts pc, flags, registers and cycles
`timescale 1ns/10ps
`include "bsb_defines.vh"
module tb_branch_skip_bitop_exec;
   logic pclk = 0, presetn = 0, pce = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire pready, pslverr, busy, done;
   wire [31:0] prdata;
   wire [15:0] pc;
   wire [7:0] status_flag_register;
   logic [7:0] gm [32];
   logic [7:0] im [64];
   logic [7:0] sm = 8'h00;
   logic [15:0] pcm = 16'h0000;
   int n_fail = 0, check_count = 0, bcnt = 0, seed = 98;
   always #20 pclk = ~pclk;
   always @(negedge pclk) if (busy === 1'b1) bcnt++;
   bsb_exec dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .busy(busy), .done(done), .pc(pc), .status_flag_register(status_flag_register));
   // ****************
   // tasks
   // ****************
   task tally_and_finish;
      begin
         if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      begin
         check_count++;
         if (seen !== exp)
         begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            n_fail++;
         end
      end
   endtask
   // no fixed latency assumed: wait on pready, bounded
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      int t;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         t = 0;
         do
         begin
            @(posedge pclk);
            t++;
         end
         while (pready !== 1'b1 && t < 50);
         // the answer is taken at the very edge that samples pready high
         if (pready !== 1'b1)
            n_fail++;
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic er;
      begin
         apb(1'b0, a, 32'h0, rd, er);
         chk(nm, rd, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d, input logic exp_er);
      logic [31:0] rd;
      logic er;
      begin
         apb(1'b1, a, d, rd, er);
         chk("write error", {31'h0, er}, {31'h0, exp_er});
      end
   endtask
   task exec(input logic [31:0] cmd, input logic hit);
      logic [4:0] op, r;
      logic [5:0] a;
      logic [2:0] b;
      logic [7:0] k, x, y;
      logic [15:0] adv;
      logic c;
      int n, t;
      begin
         op = cmd[4:0];
         r = cmd[9:5];
         a = cmd[15:10];
         b = cmd[18:16];
         k = cmd[31:24];
         x = gm[r];
         n = 1;
         adv = 16'h0001;
         if (op == 5'h00 || op > 5'h1a)
         begin
            if (op == 5'h00)
            begin
               y = x - k;
               sm[0] = x < k;
               sm[5] = x[3:0] < k[3:0];
               sm[3] = (x[7] != k[7]) && (y[7] != x[7]);
            end
            else
            begin
               y = op[0] ? {x[6:0], 1'b0} : {1'b0, x[7:1]};
               sm[0] = op[0] ? x[7] : x[0];
               sm[3] = y[7] ^ sm[0];
               gm[r] = y;
            end
            sm[1] = y == 8'h00;
            sm[2] = y[7];
            sm[4] = sm[2] ^ sm[3];
         end
         else if (op < 5'h05)
         begin
            c = (op < 5'h03 ? x[b] : im[a][b]) == (op == 5'h02 || op == 5'h04);
            n = c ? 2 + cmd[19] : 1;
            adv = 16'(n);
         end
         else if (op < 5'h19)
         begin
            case (op)
               5'h05, 5'h06: c = sm[b];
               5'h07, 5'h08: c = sm[1];
               5'h09, 5'h0a, 5'h0b, 5'h0c: c = sm[0];
               5'h0d, 5'h0e: c = sm[2];
               5'h0f, 5'h10: c = sm[2] ^ sm[3];
               5'h11, 5'h12: c = sm[5];
               5'h13, 5'h14: c = sm[6];
               5'h15, 5'h16: c = sm[3];
               default: c = sm[7];
            endcase
            c = c == (op[0] ^ (op inside {5'h0b, 5'h0c, 5'h0f, 5'h10}));
            n = c ? 2 : 1;
            if (c)
               adv = {{8{k[7]}}, k} + 16'h0001;
         end
         else
         begin
            im[a][b] = op == 5'h19;
            n = 2;
         end
         pcm = pcm + adv;
         wr(12'h000, cmd, 1'b0);
         bcnt = 0;
         if (hit)
            wr(12'h008, 32'hff, 1'b1);
         t = 0;
         while (done !== 1'b1 && t < 40)
         begin
            @(negedge pclk);
            t++;
         end
         chk("cycles", bcnt, n);
         chk("pc", {16'h0, pc}, {16'h0, pcm});
         chk("flags", {24'h0, status_flag_register}, {24'h0, sm});
         rdchk("register", 12'h100 + {5'h0, r, 2'b00}, {24'h0, gm[r]});
         rdchk("io", 12'h200 + {4'h0, a, 2'b00}, {24'h0, im[a]});
      end
   endtask
   initial
   begin
      repeat (40000) @(posedge pclk);
      n_fail++;
      tally_and_finish;
   end
   initial
   begin
      logic [31:0] d;
      logic [11:0] ba [4];
      int i;
      ba = '{12'h010, 12'h002, 12'h00c, 12'h000};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk("reset pc", {16'h0, pc}, 32'h0);
      // unmapped, misaligned, read-only and bad opcode writes
      for (i = 0; i < 4; i++)
         wr(ba[i], 32'h1d, 1'b1);
      rdchk("pc", 12'h004, 32'h0);
      rdchk("flags", 12'h008, 32'h0);
      // a frozen clock enable must hold the bus answer back
      pce <= 1'b0;
      fork
         rdchk("frozen pc", 12'h004, 32'h0);
         begin
            repeat (6) @(posedge pclk);
            chk("frozen ready", {31'h0, pready}, 32'h0);
            pce <= 1'b1;
         end
      join
      gm[0] = 8'h00;
      wr(12'h100, 32'h0, 1'b0);
      im[0] = 8'h00;
      wr(12'h200, 32'h0, 1'b0);
      exec(32'h0008_0001, 1'b1);
      for (i = 0; i < 116; i++)
      begin
         d = $random(seed);
         d[4:0] = 5'(i % 29);
         sm = 8'($random(seed));
         wr(12'h008, {24'h0, sm}, 1'b0);
         pcm = 16'($random(seed));
         wr(12'h004, {16'h0, pcm}, 1'b0);
         gm[d[9:5]] = 8'($random(seed));
         wr(12'h100 + {5'h0, d[9:5], 2'b00}, {24'h0, gm[d[9:5]]}, 1'b0);
         im[d[15:10]] = 8'($random(seed));
         wr(12'h200 + {4'h0, d[15:10], 2'b00}, {24'h0, im[d[15:10]]}, 1'b0);
         exec(d, 1'b0);
      end
      tally_and_finish;
   end
endmodule
